// ### rtl/ict_consts.vh
// Constants for the instruction cycle timing block.
`ifndef ICT_CONSTS_VH
`define ICT_CONSTS_VH
`define ICT_CLKS_PER_CYCLE  4
`define ICT_PHASE_W         2
`define ICT_PHASE_LAST      2'h3
`define ICT_PHASE_RESET     2'h0
`define ICT_CLASS_W         3
`define ICT_CLASS_ORDINARY  3'h0
`define ICT_CLASS_JUMP      3'h1
`define ICT_CLASS_CALL      3'h2
`define ICT_CLASS_RETURN    3'h3
`define ICT_CLASS_INTERRUPT_EXIT      3'h4
`define ICT_CLASS_TABLE     3'h5
`define ICT_CLASS_SKIP      3'h6
`define ICT_CLASS_BRANCH    3'h7
`endif

// ### rtl/ict_cycle_timing.v
// Instruction cycle sequencer: four-clock cycles, one or two cycles per instruction.
`timescale 1ns/1ps
`default_nettype none
`include "ict_consts.vh"

// Function
// RULE1: Every instruction cycle lasts exactly four system clocks and instructions run in whole cycles.
// RULE2: Ordinary instructions take one cycle while branch, call and table read take two.
// RULE3: Unconditional jump, subroutine call, subroutine exit and interrupt exit take one extra cycle.
// RULE4: An instruction writing the program counter low byte acts as a jump and takes one extra cycle.
// RULE5: A skip instruction takes one cycle when not skipping and one more when it skips.
// RULE6: The next instruction is prefetched during execution and discarded on a flow change.
module ict_cycle_timing (
    input  wire       core_clk_i,
    input  wire       reset_i,
    input  wire [2:0] instr_class_i,
    input  wire       pc_low_byte_write_i,
    input  wire       skip_taken_i,
    output wire       cycle_start_o,
    output wire       cycle_end_o,
    output reg  [1:0] phase_o,
    output reg        fetch_o,
    output reg        execute_o,
    output reg        extra_cycle_o,
    output reg        flush_o,
    output reg        instr_done_o
);

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    localparam [1:0] ST_FETCH_ONLY = 2'h0;
    localparam [1:0] ST_EXECUTE    = 2'h1;
    localparam [1:0] ST_EXTRA      = 2'h2;

    // ------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------
    reg  [1:0] phase_q;
    reg  [1:0] phase_d;
    wire       last_phase;

    assign last_phase = (phase_q == `ICT_PHASE_LAST);

    // The counter wraps after the last phase, so a cycle is always four clocks.
    always @* begin
        if (last_phase) begin
            phase_d = `ICT_PHASE_RESET; // [RULE1]
        end else begin
            phase_d = phase_q + 2'h1;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            phase_q <= `ICT_PHASE_RESET;
        end else begin
            phase_q <= phase_d; // [RULE1]
        end
    end

    assign cycle_start_o = (phase_q == `ICT_PHASE_RESET);
    assign cycle_end_o   = last_phase;

    // ------------------------------------------------------------
    // Instruction class decode
    // ------------------------------------------------------------
    reg        needs_extra;

    // Decides at the end of an execute cycle whether a second cycle follows.
    always @* begin
        case (instr_class_i)
            `ICT_CLASS_JUMP, `ICT_CLASS_CALL, `ICT_CLASS_RETURN, `ICT_CLASS_INTERRUPT_EXIT: begin
                needs_extra = 1'b1; // [RULE3]
            end
            `ICT_CLASS_TABLE, `ICT_CLASS_BRANCH: begin
                needs_extra = 1'b1; // [RULE2]
            end
            `ICT_CLASS_SKIP: begin
                needs_extra = skip_taken_i; // [RULE5]
            end
            default: begin
                needs_extra = 1'b0;
            end
        endcase
        if (pc_low_byte_write_i) begin
            needs_extra = 1'b1; // [RULE4]
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencing state machine
    // ------------------------------------------------------------
    reg  [1:0] state_q;
    reg  [1:0] state_d;

    // State only moves at the end of a cycle, so instructions run in whole cycles.
    always @* begin
        state_d = state_q;
        if (last_phase) begin
            case (state_q)
                ST_FETCH_ONLY: begin
                    // The first cycle after reset only fills the prefetch slot.
                    state_d = ST_EXECUTE;
                end
                ST_EXECUTE: begin
                    if (needs_extra) begin
                        state_d = ST_EXTRA; // [RULE2]
                    end
                end
                ST_EXTRA: begin
                    state_d = ST_EXECUTE; // [RULE3]
                end
                default: begin
                    state_d = ST_FETCH_ONLY;
                end
            endcase
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= ST_FETCH_ONLY;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Output next values
    // ------------------------------------------------------------
    reg        flush_d;
    reg        done_d;
    reg        execute_d;
    reg        extra_cycle_d;

    always @* begin
        flush_d       = 1'b0;
        done_d        = 1'b0;
        execute_d     = (state_q == ST_EXECUTE);
        extra_cycle_d = (state_q == ST_EXTRA);
        if (last_phase) begin
            if (state_q == ST_EXECUTE) begin
                if (needs_extra) begin
                    // The prefetched word is stale once control flow changes.
                    flush_d = 1'b1; // [RULE6]
                end else begin
                    done_d = 1'b1; // [RULE2] [RULE5]
                end
            end else if (state_q == ST_EXTRA) begin
                done_d = 1'b1; // [RULE3] [RULE4]
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            phase_o <= `ICT_PHASE_RESET;
        end else begin
            phase_o <= phase_q;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            fetch_o <= 1'b0;
        end else begin
            fetch_o <= 1'b1; // [RULE6]
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            execute_o <= 1'b0;
        end else begin
            execute_o <= execute_d; // [RULE6]
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            extra_cycle_o <= 1'b0;
        end else begin
            extra_cycle_o <= extra_cycle_d; // [RULE3]
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            flush_o <= 1'b0;
        end else begin
            flush_o <= flush_d; // [RULE6]
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            instr_done_o <= 1'b0;
        end else begin
            instr_done_o <= done_d; // [RULE1]
        end
    end

endmodule
`default_nettype wire

// ### tb/ict_monitor.sv
// Checker for the cycle timing outputs.
`timescale 1ns/1ps
`default_nettype none
module ict_monitor (input wire logic core_clk_i, reset_i, cycle_end_o, flush_o, instr_done_o,
    execute_o, extra_cycle_o);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_extra; !instr_done_o ##4 instr_done_o; endsequence
    sequence s_extra_level; extra_cycle_o [*4] ##1 !extra_cycle_o; endsequence
    chk_cycle_len: assert property (cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o)
        else $error("cycle");
    chk_flush_extra: assert property (flush_o |-> s_extra) else $error("extra");
    chk_done_gap: assert property (instr_done_o |=> !instr_done_o [*3])
        else $error("gap");
    chk_extra_level: assert property (flush_o |=> s_extra_level)
        else $error("extra level");
    chk_done_at_end: assert property (instr_done_o |-> $past(cycle_end_o))
        else $error("done phase");
    chk_flush_at_end: assert property (flush_o |-> $past(cycle_end_o))
        else $error("flush phase");
    chk_exec_excl: assert property (!(execute_o && extra_cycle_o))
        else $error("exec overlap");
endmodule
`default_nettype wire

// ### tb/ict_prog_mem.sv
// Program memory model handing out instruction words.
`timescale 1ns/1ps
`default_nettype none
module ict_prog_mem (input wire logic core_clk_i, instr_done_o,
    output wire logic [2:0] instr_class_i, output wire logic pc_low_byte_write_i, skip_taken_i);
    logic [3:0] ptr_q = 4'h0;
    always @(negedge core_clk_i) if (instr_done_o) ptr_q <= ptr_q + 4'h1;
    assign {pc_low_byte_write_i, skip_taken_i, instr_class_i} = {ptr_q == 4'h8, ptr_q};
endmodule
`default_nettype wire

// ### tb/tb.sv
// Testbench for the cycle timing block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       core_clk_i = 0, reset_i = 1;
    wire  [2:0] instr_class_i;
    wire  [1:0] phase_o;
    wire        pc_low_byte_write_i, skip_taken_i, cycle_start_o, cycle_end_o, fetch_o;
    wire        execute_o, extra_cycle_o, flush_o, instr_done_o;
    int         num_errors = 0, checks_done = 0, n, cycles = 0;
    always #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 1000) begin
            num_errors++;
            $display("test timed out after 1000 clocks");
            end_of_test;
        end
    end
    ict_prog_mem ict_prog_mem_inst (.*);
    ict_cycle_timing ict_cycle_timing_inst (.*);
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [3:0] v, e);
        checks_done++;
        if (v !== e) begin num_errors++; $display("wrong value clocks exp %0d seen %0d", e, v); end
    endtask
    // A stuck block ends each wait at twelve clocks and shows up as a wrong count.
    task automatic test_program;
        for (int i = 0; i < 17; i++) begin
            n = 0;
            do @(negedge core_clk_i) n++; while (!instr_done_o && n < 12);
            if (i) check(n[3:0], i==8||i==14||i%8%6 ? 4'h8 : 4'h4);
        end
        $display("test_program done");
    endtask
    initial begin
        repeat (16) @(negedge core_clk_i);
        reset_i = 0;
        test_program;
        end_of_test;
    end
endmodule
bind ict_cycle_timing ict_monitor ict_monitor_inst (.*);
`default_nettype wire
